/* File: hold_timer_pkg.sv */
// Purpose : Shared constants and carriers for the event hold timer control
// Assumes : Master clock clk at 50 MHz stands in for the 16 kHz master oscillator
// Notes   : Durations kept in their own units; cycle counts derived from them
package hold_timer_pkg;

	// ----------------------------------------
	// Clock and time base
	// ----------------------------------------
	localparam int unsigned CLK_HZ        = 50_000_000;
	localparam int unsigned MASTER_OSC_HZ = 16_000;
	// One master oscillator tick every this many clk cycles
	localparam int unsigned MASTER_DIV    = CLK_HZ / MASTER_OSC_HZ;

	// ----------------------------------------
	// Durations in seconds, as specified
	// ----------------------------------------
	localparam int unsigned HOLD_S        = 30;
	localparam int unsigned INIT_HIGH1_S  = 2;
	localparam int unsigned INIT_LOW_S    = 30;
	localparam int unsigned INIT_HIGH2_S  = 1;
	localparam int unsigned INIT_QUIET_S  = 32;

	// ----------------------------------------
	// Durations as master oscillator ticks
	// ----------------------------------------
	localparam int unsigned HOLD_TICKS       = HOLD_S * MASTER_OSC_HZ;
	localparam int unsigned INIT_HIGH1_TICKS = INIT_HIGH1_S * MASTER_OSC_HZ;
	localparam int unsigned INIT_LOW_TICKS   = INIT_LOW_S * MASTER_OSC_HZ;
	localparam int unsigned INIT_HIGH2_TICKS = INIT_HIGH2_S * MASTER_OSC_HZ;
	localparam int unsigned INIT_QUIET_TICKS = INIT_QUIET_S * MASTER_OSC_HZ;

	// Slow oscillator periods forming the mode two hold
	localparam int unsigned SLOW_HOLD_TICKS  = 1_800;

	localparam int unsigned CNT_W = 20;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic {
		MODE_ONE,
		MODE_TWO
	} mode_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_HOLD,
		ST_INIT_HIGH1,
		ST_INIT_LOW,
		ST_INIT_HIGH2,
		ST_INIT_QUIET
	} state_t;

	// Synchronised pin levels
	typedef struct packed {
		logic mode_select;
		logic init_trigger;
		logic inhibit_in;
		logic comp_hi;
		logic comp_lo;
		logic slow_osc_in;
	} pins_t;

endpackage : hold_timer_pkg

/* File: pin_sync.sv */
// Purpose : Two-flop synchroniser for a group of pin levels
// Assumes : Inputs are asynchronous to clk
// Notes   : First stage is read only by the second stage
`timescale 1ns/1ps
module pin_sync #(
	parameter int unsigned WIDTH = 6
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             reset_n,
	// Pins in and synchronised out
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;

	// ----------------------------------------
	// Two stages, per bit
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge clk) begin
				if (!reset_n) begin
					meta_q[i]   <= 1'b0;
					sync_out[i] <= 1'b0;
				end else begin
					meta_q[i]   <= async_in[i];
					sync_out[i] <= meta_q[i];
				end
			end
		end
	endgenerate

endmodule : pin_sync

/* File: event_hold_timer_control.sv */
// Purpose : Control logic of the event detector: output hold timer and init waveform
// Assumes : Analog comparator reports its upper and lower threshold crossings as levels
// Notes   : Master oscillator is modelled as a tick divided from clk
//
// What this block does
// - Mode one runs while mode_select is low and mode two while it is high.
// - In mode one the hold time is counted only in master oscillator ticks.
// - In mode one an event keeps the output high for 30 s and then lets it fall.
// - In mode two the hold time is counted in slow oscillator ticks.
// - In mode two the master tick keeps running but does not time the hold.
// - The mode two hold is a fixed count of slow periods, so it scales with the RC choice.
// - In mode two a high inhibit_in blocks events from reaching the output.
// - In mode one inhibit_in is ignored.
// - A detected event drives the output high.
// - An event is declared only once the amplifier swing has crossed both top and bottom thresholds.
// - A declared event starts the output and the hold timer together.
// - In mode one a rising init_trigger gives high 2 s, low 30 s, high 1 s, then low.
// - In mode two a rising init_trigger holds the output low for 32 s whatever the sensor does.
// - After the mode two quiet interval the block is armed again.
// - The slow oscillator is gated idle in mode one and runs only in mode two.
`timescale 1ns/1ps
module event_hold_timer_control
	import hold_timer_pkg::*;
#(
	parameter int unsigned MASTER_DIV_P  = hold_timer_pkg::MASTER_DIV,
	parameter int unsigned HOLD_P        = hold_timer_pkg::HOLD_TICKS,
	parameter int unsigned HIGH1_P       = hold_timer_pkg::INIT_HIGH1_TICKS,
	parameter int unsigned LOW_P         = hold_timer_pkg::INIT_LOW_TICKS,
	parameter int unsigned HIGH2_P       = hold_timer_pkg::INIT_HIGH2_TICKS,
	parameter int unsigned QUIET_P       = hold_timer_pkg::INIT_QUIET_TICKS,
	parameter int unsigned SLOW_HOLD_P   = hold_timer_pkg::SLOW_HOLD_TICKS
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic reset_n,
	// Mode and control pins
	input  wire logic mode_select,
	input  wire logic init_trigger,
	input  wire logic inhibit_in,
	// Comparator on second_amp_out: above top and below bottom reference
	input  wire logic comp_hi,
	input  wire logic comp_lo,
	// Slow oscillator
	input  wire logic slow_osc_in,
	output logic      slow_osc_en,
	// Event output and status
	output logic      event_out,
	output logic      init_busy
);
	import hold_timer_pkg::*;

	// ----------------------------------------
	// Pin synchronisation
	// ----------------------------------------
	pins_t pins_raw;
	pins_t pins_s;

	assign pins_raw = '{mode_select: mode_select, init_trigger: init_trigger,
		inhibit_in: inhibit_in, comp_hi: comp_hi, comp_lo: comp_lo, slow_osc_in: slow_osc_in};

	pin_sync #(
		.WIDTH($bits(pins_t))
	) u_sync (
		.clk      (clk),
		.reset_n  (reset_n),
		.async_in (pins_raw),
		.sync_out (pins_s)
	);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	state_t           state_q, state_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [15:0]      div_q;
	logic             mtick_q;
	logic             slow_prev_q;
	logic             init_prev_q;
	logic             seen_hi_q, seen_lo_q;
	logic             mode_q;
	logic             out_d;

	// ----------------------------------------
	// Decodes
	// ----------------------------------------
	wire   mode_two    = pins_s.mode_select;
	wire   slow_rise   = pins_s.slow_osc_in & ~slow_prev_q;
	wire   init_rise   = pins_s.init_trigger & ~init_prev_q;
	wire   swing_done  = seen_hi_q & seen_lo_q;
	wire   blocked     = mode_two & pins_s.inhibit_in;
	wire   event_ok    = swing_done & ~blocked;
	// Hold tick source depends on mode only; master tick never times the mode two hold
	wire   hold_tick   = mode_two ? slow_rise : mtick_q;
	wire   in_init     = (state_q == ST_INIT_HIGH1) || (state_q == ST_INIT_LOW) ||
	                     (state_q == ST_INIT_HIGH2) || (state_q == ST_INIT_QUIET);
	wire [CNT_W-1:0] hold_len = mode_two ? CNT_W'(SLOW_HOLD_P) : CNT_W'(HOLD_P);
	wire   cnt_zero    = (cnt_q == '0);
	wire   mode_change = mode_q != mode_two;

	// ----------------------------------------
	// Master oscillator tick divider, always running
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			div_q   <= 16'h0000;
			mtick_q <= 1'b0;
		end else begin
			div_q   <= (div_q == 16'(MASTER_DIV_P - 1)) ? 16'h0000 : div_q + 16'h0001;
			mtick_q <= (div_q == 16'(MASTER_DIV_P - 1));
		end
	end

	// ----------------------------------------
	// Edge history and swing capture
	// ----------------------------------------
	// Swing flags clear once an event is taken, so a fresh full swing is needed
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			slow_prev_q <= 1'b0;
			init_prev_q <= 1'b0;
			seen_hi_q   <= 1'b0;
			seen_lo_q   <= 1'b0;
			mode_q      <= 1'b0;
		end else begin
			slow_prev_q <= pins_s.slow_osc_in;
			init_prev_q <= pins_s.init_trigger;
			mode_q      <= mode_two;
			if (in_init || blocked) begin
				seen_hi_q <= 1'b0;
				seen_lo_q <= 1'b0;
			end else if (swing_done) begin
				// Taken swing restarts the flags; a crossing in this same cycle is kept
				seen_hi_q <= pins_s.comp_hi;
				seen_lo_q <= pins_s.comp_lo;
			end else begin
				seen_hi_q <= seen_hi_q | pins_s.comp_hi;
				seen_lo_q <= seen_lo_q | pins_s.comp_lo;
			end
		end
	end

	// ----------------------------------------
	// Main sequencer
	// ----------------------------------------
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		if (init_rise) begin
			// Init wins over events and restarts from its first phase
			if (mode_two) begin
				state_d = ST_INIT_QUIET;
				cnt_d   = CNT_W'(QUIET_P);
			end else begin
				state_d = ST_INIT_HIGH1;
				cnt_d   = CNT_W'(HIGH1_P);
			end
		end else if (mode_change && !in_init) begin
			// Switching modes mid hold drops it; the tick base is no longer valid
			state_d = ST_IDLE;
			cnt_d   = '0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (event_ok) begin
						state_d = ST_HOLD;
						cnt_d   = hold_len;
					end
				end
				ST_HOLD: begin
					if (event_ok) begin
						cnt_d = hold_len;
					end else if (hold_tick) begin
						if (cnt_q <= CNT_W'(1)) begin
							state_d = ST_IDLE;
							cnt_d   = '0;
						end else begin
							cnt_d = cnt_q - CNT_W'(1);
						end
					end
				end
				// Init phases use master ticks; events are not looked at here
				ST_INIT_HIGH1, ST_INIT_LOW, ST_INIT_HIGH2, ST_INIT_QUIET: begin
					if (mtick_q) begin
						if (cnt_q <= CNT_W'(1)) begin
							case (state_q)
								ST_INIT_HIGH1: begin
									state_d = ST_INIT_LOW;
									cnt_d   = CNT_W'(LOW_P);
								end
								ST_INIT_LOW: begin
									state_d = ST_INIT_HIGH2;
									cnt_d   = CNT_W'(HIGH2_P);
								end
								default: begin
									state_d = ST_IDLE;
									cnt_d   = '0;
								end
							endcase
						end else begin
							cnt_d = cnt_q - CNT_W'(1);
						end
					end
				end
				default: begin
					state_d = ST_IDLE;
					cnt_d   = '0;
				end
			endcase
		end
	end

	// Output level straight from the next state, so the pin is a flop
	assign out_d = (state_d == ST_HOLD) || (state_d == ST_INIT_HIGH1) ||
	               (state_d == ST_INIT_HIGH2);

	// ----------------------------------------
	// State and output registers
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state_q     <= ST_IDLE;
			cnt_q       <= '0;
			event_out   <= 1'b0;
			init_busy   <= 1'b0;
			slow_osc_en <= 1'b0;
		end else begin
			state_q     <= state_d;
			cnt_q       <= cnt_d;
			event_out   <= out_d;
			init_busy   <= (state_d != ST_IDLE) && (state_d != ST_HOLD);
			slow_osc_en <= mode_two;
		end
	end

endmodule : event_hold_timer_control

/* File: event_hold_timer_control_props.sv */
// Purpose : Port assertions for the event hold timer control
// Assumes : Shortened counts come from the parameter defaults; the bind passes no parameters
// Notes   : Windows allow for the two-flop pin synchronisers
`timescale 1ns/1ps
module event_hold_timer_control_props #(
	parameter int unsigned MASTER_DIV_P = 4,
	parameter int unsigned HOLD_P       = 10
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Pins
	input wire logic mode_select,
	input wire logic init_trigger,
	input wire logic inhibit_in,
	input wire logic comp_hi,
	input wire logic comp_lo,
	input wire logic slow_osc_in,
	// Outputs
	input wire logic slow_osc_en,
	input wire logic event_out,
	input wire logic init_busy
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	// ----------------------------------------
	// High run length; mix marks runs that a mode change or init may cut short
	// ----------------------------------------
	logic [15:0] run_q;
	logic        mix_q;
	always_ff @(posedge clk) begin
		run_q <= event_out ? run_q + 16'h0001 : 16'h0000;
		mix_q <= event_out & (mix_q | mode_select | init_busy);
	end
	property p_en_on; mode_select[*6] |-> slow_osc_en; endproperty
	a_en_on: assert property (p_en_on) else $error("slow oscillator not enabled");
	property p_en_off; !mode_select[*6] |-> !slow_osc_en; endproperty
	a_en_off: assert property (p_en_off) else $error("slow oscillator not idle");
	property p_event_rise; (!mode_select && !init_busy && !init_trigger)[*4] ##1 comp_hi
		##1 (comp_lo && !event_out) |-> ##[1:5] event_out; endproperty
	a_event_rise: assert property (p_event_rise) else $error("event did not raise output");
	property p_hold_min; $fell(event_out) && !mix_q |-> run_q >= (HOLD_P - 1) * MASTER_DIV_P; endproperty
	a_hold_min: assert property (p_hold_min) else $error("hold ended early");
	property p_inhibit; (mode_select && inhibit_in && !init_busy)[*6] |-> !$rose(event_out); endproperty
	a_inhibit: assert property (p_inhibit) else $error("inhibited event reached output");
	property p_init_one; !mode_select[*6] ##0 $rose(init_trigger) |-> ##[1:5] (event_out && init_busy); endproperty
	a_init_one: assert property (p_init_one) else $error("init did not start high");
	property p_init_two; mode_select[*6] ##0 init_busy |-> !event_out; endproperty
	a_init_two: assert property (p_init_two) else $error("output high in quiet phase");
	property p_busy_fall; $fell(init_busy) && !mode_select |-> $fell(event_out); endproperty
	a_busy_fall: assert property (p_busy_fall) else $error("init end without output fall");
endmodule : event_hold_timer_control_props

/* File: front_end_model.sv */
// Purpose : Behavioural sensor front end and slow RC oscillator
// Assumes : Each threshold crossing shows as a one-cycle comparator level
// Notes   : Oscillator rests high when disabled, as its pin is tied high then
`timescale 1ns/1ps
module front_end_model (
	// Clock
	input  wire logic clk,
	// Slow oscillator
	input  wire logic slow_osc_en,
	output logic      slow_osc_in,
	// Comparator levels
	output logic      comp_hi,
	output logic      comp_lo
);
	int half = 6;
	int cnt  = 0;
	initial begin
		slow_osc_in = 1'b1;
		comp_hi = 1'b0;
		comp_lo = 1'b0;
	end
	// Half period in clk set by the bench, standing in for the RC choice
	always @(posedge clk) begin
		cnt = slow_osc_en ? cnt + 1 : 0;
		if (!slow_osc_en)
			slow_osc_in <= #1 1'b1;
		else if (cnt >= half) begin
			slow_osc_in <= #1 ~slow_osc_in;
			cnt = 0;
		end
	end
	// Swing above the top then below the bottom reference; half skips the bottom
	task automatic swing(input bit full);
		@(posedge clk);
		#1 comp_hi = 1'b1;
		@(posedge clk);
		#1 comp_hi = 1'b0;
		comp_lo = full;
		@(posedge clk);
		#1 comp_lo = 1'b0;
	endtask : swing
endmodule : front_end_model

/* File: event_hold_timer_control_tb.sv */
// Purpose : Self-checking bench for the event hold timer control
// Assumes : Counts shortened so one master tick is four clk
// Notes   : Lengths carry slack for sync and tick phase
`timescale 1ns/1ps
module event_hold_timer_control_tb;
	localparam int DIV = 4, HOLD = 10, H1 = 4, LO = 6, H2 = 2, QT = 8, SH = 5;
	logic clk = 1'b0, reset_n = 1'b0, mode_select = 1'b0, init_trigger = 1'b0, inhibit_in = 1'b0;
	logic comp_hi, comp_lo, slow_osc_in, slow_osc_en, event_out, init_busy;
	int   failures = 0, total_checks = 0, cycles = 0, n;
	always #10 clk = ~clk;
	event_hold_timer_control #(.MASTER_DIV_P(DIV), .HOLD_P(HOLD), .HIGH1_P(H1), .LOW_P(LO),
		.HIGH2_P(H2), .QUIET_P(QT), .SLOW_HOLD_P(SH)) u_event_hold_timer_control (
		.clk(clk), .reset_n(reset_n), .mode_select(mode_select), .init_trigger(init_trigger),
		.inhibit_in(inhibit_in), .comp_hi(comp_hi), .comp_lo(comp_lo), .slow_osc_in(slow_osc_in),
		.slow_osc_en(slow_osc_en), .event_out(event_out), .init_busy(init_busy));
	front_end_model u_front_end_model (.clk(clk), .slow_osc_en(slow_osc_en), .slow_osc_in(slow_osc_in),
		.comp_hi(comp_hi), .comp_lo(comp_lo));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic give_verdict;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : give_verdict
	task automatic chk_bit(input string what, input logic exp, input logic got);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error %s expected %b seen %b", what, exp, got);
		end
	endtask : chk_bit
	task automatic chk_len(input string what, input int lo, input int hi, input int got);
		total_checks++;
		if (got < lo || got > hi) begin
			failures++;
			$display("Error %s expected %0d to %0d seen %0d", what, lo, hi, got);
		end
	endtask : chk_len
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : cyc
	// Cycles spent at one level, bounded so a stuck output cannot hang
	task automatic span(input bit busy, input logic lvl, output int k);
		k = 0;
		while ((busy ? init_busy : event_out) === lvl && k < 2000) begin
			cyc(1);
			k++;
		end
	endtask : span
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_event;
		inhibit_in = 1'b1;
		u_front_end_model.swing(1'b0);
		cyc(8);
		chk_bit("half swing", 1'b0, event_out);
		chk_bit("slow idle", 1'b0, slow_osc_en);
		u_front_end_model.swing(1'b1);
		cyc(5);
		chk_bit("event", 1'b1, event_out);
		span(0, 1'b1, n);
		chk_len("mode one hold", (HOLD - 1) * DIV - 5, HOLD * DIV, n);
		inhibit_in = 1'b0;
	endtask : t_event
	task automatic t_restart;
		u_front_end_model.swing(1'b1);
		cyc(HOLD * DIV / 2);
		u_front_end_model.swing(1'b1);
		cyc(5);
		span(0, 1'b1, n);
		chk_len("restarted hold", (HOLD - 1) * DIV - 8, HOLD * DIV, n);
	endtask : t_restart
	task automatic t_init1;
		init_trigger = 1'b1;
		cyc(5);
		chk_bit("init busy", 1'b1, init_busy);
		span(0, 1'b1, n);
		chk_len("first high", (H1 - 1) * DIV - 3, H1 * DIV, n);
		u_front_end_model.swing(1'b1);
		span(0, 1'b0, n);
		chk_len("low phase", (LO - 1) * DIV - 3, LO * DIV, n + 3);
		span(0, 1'b1, n);
		chk_len("second high", (H2 - 1) * DIV, H2 * DIV + 1, n);
		chk_bit("init done", 1'b0, init_busy);
		init_trigger = 1'b0;
	endtask : t_init1
	// Same count of slow periods at two rates; master tick must not matter
	task automatic t_slow;
		mode_select = 1'b1;
		cyc(8);
		chk_bit("slow enable", 1'b1, slow_osc_en);
		for (int h = 6; h <= 12; h += 6) begin
			u_front_end_model.half = h;
			u_front_end_model.swing(1'b1);
			cyc(5);
			span(0, 1'b1, n);
			chk_len("slow hold", (SH - 1) * 2 * h - 6, SH * 2 * h + 6, n);
		end
	endtask : t_slow
	task automatic t_inhibit;
		inhibit_in = 1'b1;
		cyc(4);
		u_front_end_model.swing(1'b1);
		cyc(8);
		chk_bit("inhibited", 1'b0, event_out);
		inhibit_in = 1'b0;
		cyc(4);
		u_front_end_model.swing(1'b1);
		cyc(5);
		chk_bit("released", 1'b1, event_out);
		span(0, 1'b1, n);
	endtask : t_inhibit
	task automatic t_init2;
		init_trigger = 1'b1;
		cyc(5);
		u_front_end_model.swing(1'b1);
		cyc(5);
		chk_bit("quiet output", 1'b0, event_out);
		span(1, 1'b1, n);
		chk_len("quiet phase", (QT - 1) * DIV - 14, QT * DIV, n);
		init_trigger = 1'b0;
		u_front_end_model.swing(1'b1);
		cyc(5);
		chk_bit("armed", 1'b1, event_out);
		mode_select = 1'b0;
		cyc(6);
		chk_bit("mode drop", 1'b0, event_out);
	endtask : t_init2
	// Hang guard, well above the few hundred cycles the run needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			give_verdict();
		end
	end
	initial begin
		cyc(10);
		reset_n = 1'b1;
		cyc(4);
		t_event();
		t_restart();
		t_init1();
		t_slow();
		t_inhibit();
		t_init2();
		give_verdict();
	end
endmodule : event_hold_timer_control_tb
// Checker defaults already match the shortened counts given to the design instance
bind event_hold_timer_control event_hold_timer_control_props
	u_event_hold_timer_control_props (.clk(clk), .reset_n(reset_n), .mode_select(mode_select),
	.init_trigger(init_trigger), .inhibit_in(inhibit_in), .comp_hi(comp_hi), .comp_lo(comp_lo),
	.slow_osc_in(slow_osc_in), .slow_osc_en(slow_osc_en), .event_out(event_out), .init_busy(init_busy));
